// >>> lfl_defines.svh
`ifndef LFL_DEFINES_SVH
`define LFL_DEFINES_SVH

// Register byte offsets
`define LFL_OFF_CTRL 12'h000
`define LFL_OFF_TRIM 12'h004
`define LFL_OFF_PDSET 12'h008
`define LFL_OFF_STATUS 12'h00c

// Control register fields
`define LFL_CTRL_ON_BIT 0
`define LFL_CTRL_RESP_BIT 1
`define LFL_CTRL_RESET 2'h0

// Trim register fields
`define LFL_TRIM_MAG_LSB 0
`define LFL_TRIM_POL_BIT 4
`define LFL_TRIM_SPAN_LSB 5
`define LFL_TRIM_SCALE_LSB 7
`define LFL_TRIM_RESET 9'h000
`define LFL_PDSET_RESET 10'h000

// Swing scale factors in 1/256 units
`define LFL_SCALE_1P000 9'h100
`define LFL_SCALE_0P833 9'h0d5
`define LFL_SCALE_0P660 9'h0a9
`define LFL_SCALE_0P500 9'h080

// Timing
`define LFL_CLK_PERIOD_PS 5000
`define LFL_NEGATE_TIME_NS 1000
`define LFL_NEGATE_CYC \
	((`LFL_NEGATE_TIME_NS * 1000 + `LFL_CLK_PERIOD_PS - 1) / `LFL_CLK_PERIOD_PS)
`define LFL_CLEAR_TIME_NS 1000
`define LFL_CLEAR_CYC \
	((`LFL_CLEAR_TIME_NS * 1000 + `LFL_CLK_PERIOD_PS - 1) / `LFL_CLK_PERIOD_PS)

`endif

// >>> lfl_host_pin.sv
`timescale 1ns/1ps
`include "lfl_defines.svh"
// Host side of the disable pin; holds each toggle for the full clear time
module lfl_host_pin #(
	parameter int HOLD = `LFL_CLEAR_CYC
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset_n,
	// Request and pin
	input wire logic clear_req,
	output logic output_off_pin
);
	int cnt;
	always_ff @(posedge sys_clk) begin
		if (!reset_n)
			cnt <= 0;
		else if (clear_req && cnt == 0)
			cnt <= HOLD;
		else if (cnt > 0)
			cnt <= cnt - 1;
	end
	assign output_off_pin = cnt != 0;
endmodule

// >>> lfl_pkg.sv
package lfl_pkg;

	typedef enum logic [1:0] {
		LFL_RUN = 2'b00,
		LFL_FAULT = 2'b01,
		LFL_OFF = 2'b10,
		LFL_WAKE = 2'b11
	} lfl_state_e;

	typedef struct packed {
		logic [1:0] drive_swing_scale;
		logic [1:0] crossing_span_sel;
		logic temp_sense_slope_polarity;
		logic [3:0] temp_sense_slope_mag;
	} lfl_trim_s;

	typedef struct packed {
		logic [9:0] bias;
		logic [7:0] modulation;
		logic [3:0] peaking;
	} lfl_drive_s;

endpackage

// >>> lfl_top.sv
`timescale 1ns/1ps
`include "lfl_defines.svh"

// Overview of operation
// (RULE_01) Slope trim: four-bit magnitude 0000 least, 1111 most; sign zero means negative.
// (RULE_02) Two-bit crossing span: 00 narrowest adjustment range, 11 widest.
// (RULE_03) Swing scale on range and step: 00 none, 01 0.833, 10 0.66, 11 0.5.
// (RULE_04) Fault when bias monitor node exceeds the 1.16V limit reference.
// (RULE_05) Fault when photodiode current exceeds 150% of its set value.
// (RULE_06) Fault when the bias code falls by more than half in one update.
// (RULE_07) Any fault with response enabled zeroes bias, modulation and peaking drive.
// (RULE_08) Enabled fault drives the fault output and latches it until recovery.
// (RULE_09) Host clears by toggling off pin or on bit for the latch clear time.
// (RULE_10) Fault output is released while off pin is high or on bit is clear.
// (RULE_11) On release without fault, prior drive resumes after the negate time.
// (RULE_12) Fault still present at release re-asserts the output and keeps drive zero.
// (RULE_13) With response disabled, faults neither zero the drive nor set the latch.
module lfl_top
	import lfl_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset_n,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Pins and monitors
	input wire logic output_off_pin,
	input wire logic bias_over_limit,
	input wire logic [9:0] pd_current_code,
	input wire logic bias_code_update,
	input wire lfl_drive_s drive_req,
	// Drive and status outputs
	output lfl_drive_s drive_out,
	output lfl_trim_s trim_out,
	output logic [8:0] swing_scale_factor,
	output logic fault_out
);

	function automatic logic hit(input logic [11:0] addr, input logic [11:0] off);
		hit = (addr[11:2] == off[11:2]);
	endfunction

	function automatic logic [8:0] scale_of(input logic [1:0] code);
		unique case (code) // RULE_03
			2'b00: scale_of = `LFL_SCALE_1P000;
			2'b01: scale_of = `LFL_SCALE_0P833;
			2'b10: scale_of = `LFL_SCALE_0P660;
			2'b11: scale_of = `LFL_SCALE_0P500;
		endcase
	endfunction

	// Register state
	logic [1:0] ctrl;
	logic [1:0] next_ctrl;
	lfl_trim_s trim;
	lfl_trim_s next_trim;
	logic [9:0] pd_set;
	logic [9:0] next_pd_set;
	logic [31:0] next_prdata;
	logic next_pready;
	logic next_pslverr;

	// Fault state
	lfl_state_e state;
	lfl_state_e next_state;
	logic [15:0] wait_cnt;
	logic [15:0] next_wait_cnt;
	logic [9:0] bias_prev;
	logic [9:0] next_bias_prev;
	logic step_drop;
	logic next_step_drop;
	logic next_fault_out;
	lfl_drive_s next_drive_out;
	lfl_trim_s next_trim_out;
	logic [8:0] next_swing_scale_factor;

	logic output_on;
	logic respond;
	logic disabled;
	logic pd_over;
	logic fault_cond;
	logic drive_on;
	logic [7:0] mod_scaled;
	logic [16:0] mod_product;
	logic [31:0] status_word;
	logic [11:0] pd_twice;
	logic [11:0] set_triple;
	logic [10:0] new_twice;

	assign output_on = ctrl[`LFL_CTRL_ON_BIT];
	assign respond = ctrl[`LFL_CTRL_RESP_BIT];
	assign disabled = output_off_pin | ~output_on;
	// Compare 2*pd against 3*set to avoid a divider
	assign pd_twice = {1'b0, pd_current_code, 1'b0};
	assign set_triple = {1'b0, pd_set, 1'b0} + {2'b00, pd_set};
	assign pd_over = pd_twice > set_triple; // RULE_05
	assign new_twice = {drive_req.bias, 1'b0};
	assign fault_cond = bias_over_limit | pd_over | step_drop; // RULE_04
	assign drive_on = (state == LFL_RUN);
	assign status_word = {26'h0000000, drive_on, step_drop, pd_over, bias_over_limit,
		state == LFL_FAULT, fault_out};

	// Register file over APB, answered in the first access cycle
	always_comb begin
		next_ctrl = ctrl;
		next_trim = trim;
		next_pd_set = pd_set;
		next_prdata = prdata;
		next_pready = 1'b0;
		next_pslverr = 1'b0;
		if (psel && !penable) begin
			next_pready = 1'b1;
			next_prdata = 32'h00000000;
			if (hit(paddr, `LFL_OFF_CTRL)) begin
				next_prdata = {30'h00000000, ctrl};
			end else if (hit(paddr, `LFL_OFF_TRIM)) begin
				next_prdata = {23'h000000, trim};
			end else if (hit(paddr, `LFL_OFF_PDSET)) begin
				next_prdata = {22'h000000, pd_set};
			end else if (hit(paddr, `LFL_OFF_STATUS)) begin
				next_prdata = status_word;
				next_pslverr = pwrite;
			end else begin
				next_pslverr = 1'b1;
			end
			if (!pwrite) begin
				next_prdata = next_pslverr ? 32'h00000000 : next_prdata;
			end else begin
				next_prdata = 32'h00000000;
			end
		end
		if (psel && penable && pready && pwrite && !pslverr) begin
			if (hit(paddr, `LFL_OFF_CTRL)) begin
				next_ctrl = pwdata[1:0];
			end
			if (hit(paddr, `LFL_OFF_TRIM)) begin
				next_trim = pwdata[8:0]; // RULE_01
			end
			if (hit(paddr, `LFL_OFF_PDSET)) begin
				next_pd_set = pwdata[9:0];
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			ctrl <= `LFL_CTRL_RESET;
			trim <= `LFL_TRIM_RESET;
			pd_set <= `LFL_PDSET_RESET;
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			ctrl <= next_ctrl;
			trim <= next_trim;
			pd_set <= next_pd_set;
			prdata <= next_prdata;
			pready <= next_pready;
			pslverr <= next_pslverr;
		end
	end

	// Fault supervisor
	always_comb begin
		next_state = state;
		next_wait_cnt = wait_cnt;
		next_bias_prev = bias_prev;
		next_step_drop = 1'b0;
		if (bias_code_update) begin
			next_bias_prev = drive_req.bias;
			// Drop of more than half: 2*new < old
			next_step_drop = new_twice < {1'b0, bias_prev}; // RULE_06
		end
		unique case (state)
			LFL_RUN: begin
				if (fault_cond && respond) begin
					next_state = LFL_FAULT; // RULE_13
				end else if (disabled) begin
					next_state = LFL_OFF;
				end
			end
			LFL_FAULT: begin
				// Latched until the host toggles a disable
				if (disabled) begin
					next_state = LFL_OFF; // RULE_09
				end
			end
			LFL_OFF: begin
				if (!disabled) begin
					if (fault_cond && respond) begin
						next_state = LFL_FAULT; // RULE_12
					end else begin
						next_state = LFL_WAKE;
						next_wait_cnt = 16'h0000;
					end
				end
			end
			LFL_WAKE: begin
				next_wait_cnt = wait_cnt + 16'h0001;
				if (disabled) begin
					next_state = LFL_OFF;
				end else if (fault_cond && respond) begin
					next_state = LFL_FAULT;
				end else if (wait_cnt >= 16'(`LFL_NEGATE_CYC - 1)) begin
					next_state = LFL_RUN; // RULE_11
				end
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			state <= LFL_OFF;
			wait_cnt <= 16'h0000;
			bias_prev <= 10'h000;
			step_drop <= 1'b0;
		end else begin
			state <= next_state;
			wait_cnt <= next_wait_cnt;
			bias_prev <= next_bias_prev;
			step_drop <= next_step_drop;
		end
	end

	// Drive and fault outputs follow the next state so the drive cuts in the fault cycle
	assign mod_product = drive_req.modulation * next_swing_scale_factor;
	assign mod_scaled = mod_product[15:8];

	always_comb begin
		next_swing_scale_factor = scale_of(trim.drive_swing_scale);
		next_trim_out = trim; // RULE_02
		next_fault_out = (next_state == LFL_FAULT); // RULE_08
		next_drive_out = '0; // RULE_07
		if (next_state == LFL_RUN) begin
			next_drive_out.bias = drive_req.bias;
			next_drive_out.modulation = mod_scaled;
			next_drive_out.peaking = drive_req.peaking;
		end
		if (disabled) begin
			next_fault_out = 1'b0; // RULE_10
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			drive_out <= '0;
			trim_out <= `LFL_TRIM_RESET;
			swing_scale_factor <= `LFL_SCALE_1P000;
			fault_out <= 1'b0;
		end else begin
			drive_out <= next_drive_out;
			trim_out <= next_trim_out;
			swing_scale_factor <= next_swing_scale_factor;
			fault_out <= next_fault_out;
		end
	end

endmodule

// >>> lfl_top_asserts.sv
`timescale 1ns/1ps
module lfl_top_asserts
	import lfl_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset_n,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Pins and drive
	input wire logic output_off_pin,
	input wire lfl_drive_s drive_out,
	input wire lfl_trim_s trim_out,
	input wire logic [8:0] swing_scale_factor,
	input wire logic fault_out
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	a_ready_after_setup: assert property (psel && !penable |=> pready) else $error("no ready");
	a_ready_one_cycle: assert property (pready |=> !pready) else $error("ready too long");
	a_err_no_data: assert property (pslverr |-> pready && prdata == '0) else $error("bad error");
	a_scale_map: assert property ($stable(trim_out) |-> swing_scale_factor ==
		(trim_out.drive_swing_scale == 2'h0 ? 9'h100 : trim_out.drive_swing_scale == 2'h1 ?
		9'h0d5 : trim_out.drive_swing_scale == 2'h2 ? 9'h0a9 : 9'h080)) else $error("bad scale");
	a_fault_zero: assert property (fault_out |-> drive_out == '0) else $error("drive on");
	a_off_release: assert property (output_off_pin |=> !fault_out) else $error("fault held");
	a_rise_not_off: assert property ($rose(fault_out) |-> !$past(output_off_pin))
		else $error("fault while off");
	a_off_drive: assert property (output_off_pin |=> drive_out == '0) else $error("drive");
	a_wake_hold: assert property ($fell(output_off_pin) |=> (drive_out == '0) [*8])
		else $error("early drive");
endmodule

// >>> lfl_top_tb.sv
`timescale 1ns/1ps
module lfl_top_tb
	import lfl_pkg::*;
;
	logic sys_clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd;
	logic ovr = 0, upd = 0, clr = 0, off, fo, er;
	logic [9:0] pd = '0;
	lfl_drive_s req = '{10'h200, 8'h80, 4'h5}, dout;
	lfl_trim_s trim;
	logic [8:0] scl;
	int err_count = 0, total_checks = 0, tmo = 0;
	lfl_top i_lfl_top(.sys_clk(sys_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .output_off_pin(off), .bias_over_limit(ovr), .pd_current_code(pd),
		.bias_code_update(upd), .drive_req(req), .drive_out(dout), .trim_out(trim),
		.swing_scale_factor(scl), .fault_out(fo));
	lfl_host_pin i_lfl_host_pin(.sys_clk(sys_clk), .reset_n(reset_n), .clear_req(clr),
		.output_off_pin(off));
	initial begin
		forever #2.5 sys_clk = ~sys_clk;
	end
	task report_and_stop();
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	always @(posedge sys_clk) begin
		tmo <= tmo + 1;
		if (tmo == 20000) begin
			err_count++;
			report_and_stop();
		end
	end
	task cyc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	task chk(input string s, input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value %s exp %h got %h", s, exp, got);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1;
		do begin
			@(posedge sys_clk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
		// Idle edge so a following call never re-drives psel in this step
		@(posedge sys_clk);
	endtask
	// Clear through the pin; drive stays off for the hold plus the negate time
	task clear_fault();
		clr <= 1;
		cyc(1);
		clr <= 0;
		cyc(3);
		chk("fault off", fo, 0);
		cyc(410);
	endtask
	task t_regs();
		logic [8:0] tab[4] = '{9'h100, 9'h0d5, 9'h0a9, 9'h080};
		for (int i = 0; i < 4; i++) begin
			apb(1, 12'h004, {23'h0, i[1:0], 2'h2, 1'b1, 4'hf});
			cyc(2);
			chk("trim", trim, {i[1:0], 2'h2, 1'b1, 4'hf});
			chk("scale", scl, tab[i]);
		end
		apb(0, 12'h004, 32'h0);
		chk("trim read", rd, 32'h000001df);
		apb(0, 12'h010, 32'h0);
		chk("unmapped", {er, rd[30:0]}, 32'h80000000);
		apb(1, 12'h00c, 32'h1);
		chk("ro status", er, 1);
	endtask
	task t_fault();
		apb(1, 12'h008, 32'h40);
		apb(1, 12'h000, 32'h3);
		cyc(210);
		chk("run drive", dout, {10'h200, 8'h40, 4'h5});
		ovr <= 1;
		cyc(2);
		chk("bias fault", {fo, dout}, 23'h400000);
		ovr <= 0;
		cyc(5);
		chk("latched", fo, 1);
		apb(0, 12'h00c, 32'h0);
		chk("status", rd, 32'h00000003);
		clear_fault();
		chk("resume", dout, {10'h200, 8'h40, 4'h5});
		pd <= 10'h60;
		cyc(3);
		chk("pd at limit", fo, 0);
		pd <= 10'h61;
		cyc(2);
		chk("pd fault", fo, 1);
		clr <= 1;
		cyc(1);
		clr <= 0;
		cyc(205);
		chk("refault", {fo, dout}, 23'h400000);
		pd <= 10'h20;
		clear_fault();
		upd <= 1;
		cyc(1);
		req.bias <= 10'h0ff;
		cyc(1);
		upd <= 0;
		cyc(3);
		chk("drop fault", fo, 1);
		clear_fault();
	endtask
	task t_noresp();
		apb(1, 12'h000, 32'h1);
		ovr <= 1;
		cyc(4);
		chk("no latch", {fo, dout}, {1'b0, 10'h0ff, 8'h40, 4'h5});
		ovr <= 0;
	endtask
	initial begin
		cyc(8);
		reset_n <= 1;
		cyc(1);
		t_regs();
		t_fault();
		t_noresp();
		report_and_stop();
	end
endmodule
bind lfl_top lfl_top_asserts i_lfl_top_asserts(.sys_clk(sys_clk), .reset_n(reset_n),
	.psel(psel), .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.output_off_pin(output_off_pin), .drive_out(drive_out), .trim_out(trim_out),
	.swing_scale_factor(swing_scale_factor), .fault_out(fault_out));
